// ==== hw/sacq_top.sv ====
// Digital side of a sampling converter: frame sequencer, standby control,
// and three-state serial result output.
// Assumes strobe, shift clock, variant strap and input code are asynchronous
// pins, and that the shift clock is well below a quarter of I_CLK.
`include "sacq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sacq_top import sacq_pkg::*; (
	input  wire logic               I_CLK,
	input  wire logic               I_RST,
	input  wire logic               I_CONVERSION_STROBE,
	input  wire logic               I_SHIFT_CLOCK,
	input  wire logic               I_VARIANT_14,
	input  wire logic signed [15:0] I_INPUT_CODE,
	output logic                    O_SERIAL_RESULT_OUT,
	output logic                    O_SERIAL_RESULT_OE,
	output logic                    O_LIGHT_STANDBY,
	output logic                    O_DEEP_STANDBY,
	output logic                    O_REF_POWERED,
	output logic                    O_TRACKING
);
	sacq_edge_if conversion_strobe_if ();
	sacq_edge_if sck_if ();
	sacq_edge_if var_if ();
	sacq_sar_if  sar_if ();

	sacq_power_type          power;
	sacq_power_type          next_power;
	logic [`SACQ_STB_W-1:0]  strobes;
	logic [`SACQ_STB_W-1:0]  next_strobes;
	logic [`SACQ_STB_W-1:0]  base_strobes;
	sacq_conversion_strobe_type           conversion_strobe_state;
	sacq_conversion_strobe_type           next_conversion_strobe_state;
	logic [`SACQ_CNT_W-1:0]  edge_cnt;
	logic [`SACQ_CNT_W-1:0]  next_edge_cnt;
	logic [`SACQ_CNT_W-1:0]  last_edge;
	logic                    oe;
	logic                    next_oe;
	logic                    wide;
	logic                    next_wide;
	logic signed [15:0]      code_meta;
	logic signed [15:0]      code_sync;
	logic signed [15:0]      next_code_meta;
	logic signed [15:0]      next_code_sync;
	logic                    start;
	logic                    step;

	// Pin synchronisers; strobe, shift clock and strap each pass two flops before any logic.
	sacq_edge_sync u_conversion_strobe_sync (
		.i_clk   (I_CLK),
		.i_rst   (I_RST),
		.i_pin   (I_CONVERSION_STROBE),
		.edge_if (conversion_strobe_if)
	);
	sacq_edge_sync u_sck_sync (
		.i_clk   (I_CLK),
		.i_rst   (I_RST),
		.i_pin   (I_SHIFT_CLOCK),
		.edge_if (sck_if)
	);
	sacq_edge_sync u_var_sync (
		.i_clk   (I_CLK),
		.i_rst   (I_RST),
		.i_pin   (I_VARIANT_14),
		.edge_if (var_if)
	);

	// The input code is treated as quasi-static; a wide two-flop stage is
	// enough because it is only sampled at a strobe edge.
	always_comb begin
		next_code_meta = I_INPUT_CODE;
		next_code_sync = code_meta;
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			code_meta <= 16'sh0000;
			code_sync <= 16'sh0000;
		end else begin
			code_meta <= next_code_meta;
			code_sync <= next_code_sync;
		end
	end

	// The variant strap is caught while reset is held and kept afterwards.
	always_comb begin
		next_wide = I_RST ? var_if.level : wide;
	end

	always_ff @(posedge I_CLK) begin
		wide <= next_wide;
	end

	// Strobe rises are counted since the last shift clock rise; a shift
	// clock rise in the same cycle is taken as coming first.
	always_comb begin
		base_strobes = sck_if.rise ? 3'h0 : strobes; // R4
		next_strobes = base_strobes;
		if (conversion_strobe_if.rise && (base_strobes < `SACQ_STB_DEEP)) begin
			next_strobes = base_strobes + 3'h1;
		end
		if (next_strobes >= `SACQ_STB_DEEP) begin
			next_power = PWR_DEEP; // R5
		end else if (next_strobes >= `SACQ_STB_LIGHT) begin
			next_power = PWR_LIGHT; // R2
		end else begin
			next_power = PWR_ACTIVE; // R4
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			strobes <= 3'h0; // R1
			power   <= PWR_ACTIVE; // R1
		end else begin
			strobes <= next_strobes;
			power   <= next_power;
		end
	end

	// Frame sequencer. A strobe is only honoured while tracking or after
	// the sixteenth clock rise; entering standby abandons the frame so
	// that the data pin is released and a fresh strobe starts over.
	always_comb begin
		last_edge       = wide ? `SACQ_EDGE_LAST14 : `SACQ_EDGE_LAST12; // R13
		next_conversion_strobe_state = conversion_strobe_state;
		next_edge_cnt   = edge_cnt;
		start           = 1'b0;
		step            = 1'b0;
		unique case (conversion_strobe_state)
			CV_TRACK: begin
				if (conversion_strobe_if.rise) begin
					start = 1'b1; // R7
				end
			end
			CV_CONVERT: begin
				if (sck_if.rise) begin
					next_edge_cnt = edge_cnt + 5'h01; // R11
					step = (next_edge_cnt >= `SACQ_EDGE_FIRST) &&
						(next_edge_cnt <= last_edge); // R12
					if (next_edge_cnt == `SACQ_EDGE_TRACK) begin
						next_conversion_strobe_state = CV_TAIL; // R7
					end
				end
			end
			CV_TAIL: begin
				if (sck_if.rise) begin
					next_edge_cnt   = `SACQ_EDGE_HIZ; // R16
					next_conversion_strobe_state = CV_TRACK;
				end else if (conversion_strobe_if.rise) begin
					start = 1'b1; // R7
				end
			end
		endcase
		if (start) begin
			next_conversion_strobe_state = CV_CONVERT;
			next_edge_cnt   = 5'h00;
		end
		if (next_power != PWR_ACTIVE) begin
			start           = 1'b0;
			step            = 1'b0;
			next_conversion_strobe_state = CV_TRACK;
			next_edge_cnt   = `SACQ_EDGE_HIZ;
		end
		// Bits 3..16 (3..14 when narrow) of the frame carry the result; the 14-bit result is right-justified in 16.
		next_oe = (next_conversion_strobe_state != CV_TRACK) &&
			(next_edge_cnt >= `SACQ_EDGE_FIRST) &&
			(next_edge_cnt <= last_edge); // R15
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			conversion_strobe_state <= CV_TRACK; // R1
			edge_cnt   <= `SACQ_EDGE_HIZ;
			oe         <= 1'b0; // R16
		end else begin
			conversion_strobe_state <= next_conversion_strobe_state;
			edge_cnt   <= next_edge_cnt;
			oe         <= next_oe; // R16
		end
	end

	// Drive the core; the sample is taken at the strobe edge.
	assign sar_if.load   = start;
	assign sar_if.step   = step; // R11
	assign sar_if.wide   = wide;
	assign sar_if.sample = code_sync;

	sacq_sar u_sar (
		.i_clk  (I_CLK),
		.i_rst  (I_RST),
		.sar_if (sar_if)
	);

	// Bit and enable both settle one cycle after the synchronised edge,
	// well inside one shift clock period.
	assign O_SERIAL_RESULT_OUT = sar_if.bit_val; // R17
	assign O_SERIAL_RESULT_OE  = oe;
	assign O_LIGHT_STANDBY     = (power == PWR_LIGHT);
	assign O_DEEP_STANDBY      = (power == PWR_DEEP);
	assign O_REF_POWERED       = (power != PWR_DEEP); // R3
	assign O_TRACKING          = (conversion_strobe_state == CV_TRACK);

	a_reset_active : assert property (@(posedge I_CLK) // R1
		I_RST |=> (power == PWR_ACTIVE) && !O_SERIAL_RESULT_OE && O_TRACKING)
		else $error("not active and idle after reset");

	a_light_entry : assert property (@(posedge I_CLK) disable iff (I_RST) // R2
		(strobes == 3'h1) && conversion_strobe_if.rise && !sck_if.rise |=> O_LIGHT_STANDBY)
		else $error("second strobe without clock did not enter light standby");

	a_ref_light : assert property (@(posedge I_CLK) disable iff (I_RST) // R3
		O_LIGHT_STANDBY |-> O_REF_POWERED && !O_DEEP_STANDBY)
		else $error("reference off during light standby");

	a_wake_edge : assert property (@(posedge I_CLK) disable iff (I_RST) // R4
		sck_if.rise && !conversion_strobe_if.rise |=> !O_LIGHT_STANDBY && !O_DEEP_STANDBY)
		else $error("shift clock rise did not wake the block");

	a_deep_entry : assert property (@(posedge I_CLK) disable iff (I_RST) // R5
		(strobes == 3'h3) && conversion_strobe_if.rise && !sck_if.rise
		|=> O_DEEP_STANDBY && !O_REF_POWERED)
		else $error("fourth strobe without clock did not enter deep standby");

	a_strobe_ignored : assert property (@(posedge I_CLK) disable iff (I_RST) // R7
		(conversion_strobe_state == CV_CONVERT) && (strobes == 3'h0) && conversion_strobe_if.rise
		&& !sck_if.rise |=> (conversion_strobe_state == CV_CONVERT) && $stable(edge_cnt))
		else $error("strobe during conversion was not ignored");

	a_data_start : assert property (@(posedge I_CLK) disable iff (I_RST) // R12
		(conversion_strobe_state == CV_CONVERT) && (edge_cnt == 5'h02) && sck_if.rise
		&& !conversion_strobe_if.rise |=> O_SERIAL_RESULT_OE)
		else $error("data not driven from the third clock rise");

	a_data_end : assert property (@(posedge I_CLK) disable iff (I_RST) // R13
		(conversion_strobe_state == CV_TAIL) && sck_if.rise |=> !O_SERIAL_RESULT_OE ##1
		!O_SERIAL_RESULT_OE)
		else $error("data still driven after the seventeenth clock rise");

	a_hiz_track : assert property (@(posedge I_CLK) disable iff (I_RST) // R16
		O_TRACKING |-> !O_SERIAL_RESULT_OE)
		else $error("data pin driven while tracking");

	a_step_edge : assert property (@(posedge I_CLK) disable iff (I_RST) // R11
		sar_if.step |-> sck_if.rise ##1 O_SERIAL_RESULT_OE)
		else $error("bit update not tied to a shift clock rise");

	c_full_frame : cover property (@(posedge I_CLK) disable iff (I_RST)
		(conversion_strobe_state == CV_CONVERT) && sck_if.rise && (edge_cnt == 5'h0f));
	c_light : cover property (@(posedge I_CLK) disable iff (I_RST)
		$rose(O_LIGHT_STANDBY));
	c_deep : cover property (@(posedge I_CLK) disable iff (I_RST)
		$rose(O_DEEP_STANDBY));
	c_back_to_back : cover property (@(posedge I_CLK) disable iff (I_RST)
		(conversion_strobe_state == CV_TAIL) && conversion_strobe_if.rise);

endmodule : sacq_top
`default_nettype wire

// ==== inc/sacq_consts.svh ====
// Constants for the serial sampling converter readout and standby block.
// Assumes it is included by bare name by every file that needs a count,
// width, field limit or reset value; definitions only.
//
// Overview of operation
// R1: After power-up the block is active, ready to convert, with no standby.
// R2: Two strobe rises without a shift clock rise enter light standby.
// R3: Light standby keeps the internal reference powered.
// R4: Any shift clock rise wakes from either standby; conversion may follow.
// R5: Four strobe rises without a shift clock rise enter deep standby.
// R6: The master enters deep standby at most once every 2 ms.
// R7: A strobe rise starts conversion; further rises ignored for 16 clock rises.
// R8: The master gives at least 17 clock rises between strobe rises.
// R9: One extra clock period gives the sample-and-hold 39 ns acquisition.
// R10: Strobe duty cycle is free; keep it low over 15 ns before rising.
// R11: Each shift clock rise steps the conversion and updates the output bit; the code steps only on rises 3..16 (3..14 when narrow).
// R12: Result bits leave MSB first from the third clock rise after the strobe.
// R13: The whole result is delivered within 16 clock periods after the strobe.
// R14: The master captures the result on the shift clock falling edge.
// R15: With 17 or more clocks the 14-bit result is right-justified in 16 bits.
// R16: The data pin is undriven after power-up and whenever not sending bits.
// R17: Each bit is valid by the next shift clock rise after its launch.
// R18: The result is natural binary, 16384 or 4096 steps of full scale.
// R19: Over full scale the code saturates at ones, below zero at zeros.
// R20: The receiver masks undriven word positions and keeps the result field.
`ifndef SACQ_CONSTS_SVH
`define SACQ_CONSTS_SVH

`define SACQ_CODE_W      14
`define SACQ_IN_W        16
`define SACQ_CNT_W       5
`define SACQ_STB_W       3
`define SACQ_POS_W       4
`define SACQ_MSB14       4'h0d
`define SACQ_MSB12       4'h0b
`define SACQ_EDGE_FIRST  5'h03
`define SACQ_EDGE_LAST14 5'h10
`define SACQ_EDGE_LAST12 5'h0e
`define SACQ_EDGE_TRACK  5'h10
`define SACQ_EDGE_HIZ    5'h11
`define SACQ_STB_LIGHT   3'h2
`define SACQ_STB_DEEP    3'h4
`define SACQ_CODE_MAX    14'h3fff
`define SACQ_CODE_ZERO   14'h0000
`define SACQ_IN_MAX      16'sh3fff
`define SACQ_NARROW_SH   2

`endif

// ==== inc/sacq_pkg.sv ====
// Types shared by the converter readout modules.
// Assumes the constants header is visible wherever these types are used.
package sacq_pkg;

	// Power state, one-hot.
	typedef enum logic [2:0] {
		PWR_ACTIVE = 3'b001,
		PWR_LIGHT  = 3'b010,
		PWR_DEEP   = 3'b100
	} sacq_power_type;

	// Conversion frame state, one-hot.
	typedef enum logic [2:0] {
		CV_TRACK   = 3'b001,
		CV_CONVERT = 3'b010,
		CV_TAIL    = 3'b100
	} sacq_conversion_strobe_type;

	typedef logic [13:0] sacq_code_type;

endpackage : sacq_pkg

// ==== inc/sacq_edge_if.sv ====
// Carrier for a synchronised pin level and its rising-edge pulse.
// Assumes a single clock domain shared by source and destination.
`timescale 1ns/1ps
`default_nettype none
interface sacq_edge_if;
	logic level;
	logic rise;
	modport src (output level, output rise);
	modport dst (input level, input rise);
endinterface : sacq_edge_if
`default_nettype wire

// ==== inc/sacq_sar_if.sv ====
// Carrier between the frame sequencer and the successive-approximation core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface sacq_sar_if;
	import sacq_pkg::*;
	logic                load;
	logic                step;
	logic                wide;
	logic signed [15:0]  sample;
	logic                bit_val;
	modport ctl (output load, output step, output wide, output sample, input bit_val);
	modport sar (input load, input step, input wide, input sample, output bit_val);
endinterface : sacq_sar_if
`default_nettype wire

// ==== hw/sacq_edge_sync.sv ====
// Two-flop synchroniser with rising-edge detection for one pin.
// Assumes the pin is asynchronous to i_clk and its pulses last several cycles.
`timescale 1ns/1ps
`default_nettype none
module sacq_edge_sync (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_pin,
	sacq_edge_if.src  edge_if
);
	logic meta;
	logic stable;
	logic prev;
	logic next_meta;
	logic next_stable;
	logic next_prev;

	// Only the second flop and the history flop feed the edge detector.
	always_comb begin
		next_meta   = i_pin;
		next_stable = meta;
		next_prev   = stable;
	end

	// The chain keeps sampling through reset so that a strap level has
	// settled before reset ends; the history flop follows the second flop,
	// so no false edge appears at release.
	always_ff @(posedge i_clk) begin
		meta   <= next_meta;
		stable <= next_stable;
		prev   <= next_prev;
	end

	// The rise pulse lasts one cycle per pin edge and is held off in reset.
	assign edge_if.level = stable;
	assign edge_if.rise  = stable & ~prev & ~i_rst;

endmodule : sacq_edge_sync
`default_nettype wire

// ==== hw/sacq_sar.sv ====
// Successive-approximation core: holds a sample and decides one bit per step.
// Assumes load and step are one-cycle pulses that never coincide.
`include "sacq_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sacq_sar import sacq_pkg::*; (
	input  wire logic i_clk,
	input  wire logic i_rst,
	sacq_sar_if.sar   sar_if
);
	sacq_code_type          held;
	sacq_code_type          result;
	logic [`SACQ_POS_W-1:0] pos;
	logic                   bit_val;
	sacq_code_type          next_held;
	sacq_code_type          next_result;
	logic [`SACQ_POS_W-1:0] next_pos;
	logic                   next_bit_val;
	sacq_code_type          trial;
	logic                   first_pend;
	logic                   next_first_pend;

	// Clamp the input to the code range, then drop to 12 bits if narrow.
	function automatic sacq_code_type saturate(input logic signed [15:0] v,
		input logic wide);
		sacq_code_type c;
		if (v < 16'sh0000) begin
			c = `SACQ_CODE_ZERO; // R19
		end else if (v > `SACQ_IN_MAX) begin
			c = `SACQ_CODE_MAX; // R19
		end else begin
			c = v[13:0];
		end
		saturate = wide ? c : (c >> `SACQ_NARROW_SH); // R18
	endfunction : saturate

	// Each step trials the next weight against the held value.
	always_comb begin
		trial        = result | (14'h0001 << pos);
		next_held    = held;
		next_result  = result;
		next_pos     = pos;
		next_bit_val = bit_val;
		if (sar_if.load) begin
			next_held    = saturate(sar_if.sample, sar_if.wide);
			next_result  = `SACQ_CODE_ZERO;
			next_pos     = sar_if.wide ? `SACQ_MSB14 : `SACQ_MSB12;
			next_bit_val = 1'b0;
		end else if (sar_if.step) begin
			next_bit_val = (held >= trial); // R11
			next_result  = (held >= trial) ? trial : result; // R18
			next_pos     = (pos != 4'h0) ? pos - 4'h1 : pos;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			held    <= `SACQ_CODE_ZERO;
			result  <= `SACQ_CODE_ZERO;
			pos     <= `SACQ_MSB14;
			bit_val <= 1'b0;
		end else begin
			held    <= next_held;
			result  <= next_result;
			pos     <= next_pos;
			bit_val <= next_bit_val;
		end
	end

	assign sar_if.bit_val = bit_val;

	// Check helper: high from a load until the first step after it, so the
	// first-bit check needs no open-ended wait between load and step.
	always_comb begin
		next_first_pend = first_pend;
		if (sar_if.load) begin
			next_first_pend = 1'b1;
		end else if (sar_if.step) begin
			next_first_pend = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			first_pend <= 1'b0;
		end else begin
			first_pend <= next_first_pend;
		end
	end

	a_sat_high : assert property (@(posedge i_clk) disable iff (i_rst) // R19
		sar_if.load && sar_if.wide && (sar_if.sample > `SACQ_IN_MAX)
		|=> held == `SACQ_CODE_MAX)
		else $error("over-range sample did not saturate high");
	a_sat_low : assert property (@(posedge i_clk) disable iff (i_rst) // R19
		sar_if.load && (sar_if.sample < 16'sh0000) |=> held == `SACQ_CODE_ZERO)
		else $error("negative sample did not saturate low");
	a_msb_first : assert property (@(posedge i_clk) disable iff (i_rst) // R12
		first_pend && sar_if.step
		|=> bit_val == (sar_if.wide ? held[13] : held[11]))
		else $error("first bit out is not the MSB");

endmodule : sacq_sar
`default_nettype wire

// ==== verif/sacq_master.sv ====
// Model of the serial receive master: drives the strobe and shift clock, captures the data line.
// Assumes the bench resolves the data wire, including its undriven level.
`timescale 1ns/1ps
`default_nettype none
module sacq_master (
	input  wire logic i_clk,
	input  wire logic i_sdo,
	output logic      o_strobe,
	output logic      o_sck
);
	localparam int HALF_NS = 40;

	// Both lines idle low; the shift clock stands still between frames.
	initial begin
		o_strobe = 1'b0;
		o_sck    = 1'b0;
	end

	// Lone strobe pulse with no shift clock, used to select a standby.
	task automatic strobe_pulse();
		@(posedge i_clk);
		#1;
		o_strobe = 1'b1;
		#(HALF_NS);
		o_strobe = 1'b0;
		#(HALF_NS);
	endtask : strobe_pulse

	// Single shift clock period with no strobe, used to wake the device.
	task automatic sck_pulse();
		@(posedge i_clk);
		#1;
		o_sck = 1'b1;
		#(HALF_NS);
		o_sck = 1'b0;
		#(HALF_NS);
	endtask : sck_pulse

	// One frame: strobe, then nclk shift clocks, at least 17; word keeps falls 1..16.
	// An extra strobe rises at fall number extra, to probe the ignore window.
	task automatic do_frame(input int nclk, input int extra, input logic [15:0] mask,
			output logic [15:0] word);
		int i;
		word = 16'h0000;
		if (nclk < 17) nclk = 17;
		@(posedge i_clk);
		#1;
		o_strobe = 1'b1;
		#(HALF_NS);
		for (i = 1; i <= nclk; i++) begin
			o_sck    = 1'b1;
			o_strobe = 1'b0;
			#(HALF_NS);
			o_sck = 1'b0;
			if (i <= 16) word = {word[14:0], i_sdo};
			if (i == extra) o_strobe = 1'b1;
			#(HALF_NS);
		end
		// Positions outside the result field are undriven and carry no meaning.
		word = word & mask;
	endtask : do_frame
endmodule : sacq_master
`default_nettype wire

// ==== verif/test_sacq_top.sv ====
// Self-checking bench for the converter readout and standby block.
// Assumes the master model drives the link pins and the bench resolves the data wire.
`timescale 1ns/1ps
`default_nettype none
module test_sacq_top;
	localparam int DLY = 1;
	localparam logic signed [15:0] CODES [8] = '{16'sh0000, 16'sh0001, 16'sh2aaa,
		16'sh1555, 16'sh3fff, -16'sd5, 16'sd20000, 16'sh2001};

	logic               I_CLK;
	logic               I_RST;
	logic               I_VARIANT_14;
	logic signed [15:0] I_INPUT_CODE;
	logic               strobe;
	logic               sck;
	logic               sdo_out;
	logic               sdo_oe;
	logic               light;
	logic               deep;
	logic               ref_on;
	logic               tracking;
	logic        [15:0] oe_hist;
	logic               trk_first;
	int                 fall_n;
	int                 fail_count;
	int                 num_checks;
	wire logic          sdo_wire;
	wire logic   [15:0] power_view;

	// No pull on the data line; a released wire shows the inverse of its last bit.
	assign sdo_wire   = sdo_oe ? sdo_out : ~sdo_out;
	assign power_view = {11'h000, light, deep, ref_on, sdo_oe, tracking};

	sacq_top i_sacq_top (
		.I_CLK               (I_CLK),
		.I_RST               (I_RST),
		.I_CONVERSION_STROBE (strobe),
		.I_SHIFT_CLOCK       (sck),
		.I_VARIANT_14        (I_VARIANT_14),
		.I_INPUT_CODE        (I_INPUT_CODE),
		.O_SERIAL_RESULT_OUT (sdo_out),
		.O_SERIAL_RESULT_OE  (sdo_oe),
		.O_LIGHT_STANDBY     (light),
		.O_DEEP_STANDBY      (deep),
		.O_REF_POWERED       (ref_on),
		.O_TRACKING          (tracking)
	);

	sacq_master i_sacq_master (
		.i_clk    (I_CLK),
		.i_sdo    (sdo_wire),
		.o_strobe (strobe),
		.o_sck    (sck)
	);

	// System clock, 10 ns period.
	initial begin
		I_CLK = 1'b0;
		forever #5 I_CLK = ~I_CLK;
	end

	// Record the enable at the first 16 shift clock falls of a frame.
	always @(negedge sck) begin
		if (fall_n == 0) trk_first = tracking;
		if (fall_n < 16) begin
			oe_hist = {oe_hist[14:0], sdo_oe};
			fall_n++;
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		if (fail_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	// Saturating 14-bit code from the signed input.
	function automatic logic [13:0] sat14(input logic signed [15:0] c);
		if (c < 0) return 14'h0000;
		if (c > 16'sd16383) return 14'h3fff;
		return c[13:0];
	endfunction : sat14

	// Reset for 12 cycles with the strap held, then check the idle state.
	task automatic do_reset(input logic v14);
		@(posedge I_CLK);
		#DLY;
		I_RST        = 1'b1;
		I_VARIANT_14 = v14;
		repeat (12) @(posedge I_CLK);
		#DLY;
		I_RST = 1'b0;
		@(posedge I_CLK);
		#DLY;
		check(power_view, 16'h0005);
	endtask : do_reset

	// One frame with the given code; checks data, enable window and tracking.
	task automatic run_frame(input logic signed [15:0] code, input int nclk, input int extra,
			input logic v14);
		logic [15:0] word;
		logic [15:0] mask;
		logic [15:0] exp;
		mask = v14 ? 16'h3fff : 16'h3ffc;
		exp  = {2'b00, sat14(code)} & mask;
		@(posedge I_CLK);
		#DLY;
		I_INPUT_CODE = code;
		repeat (4) @(posedge I_CLK);
		fall_n = 0;
		i_sacq_master.do_frame(nclk, extra, mask, word);
		check(word, exp);
		check(oe_hist, mask);
		check({15'h0000, trk_first}, 16'h0000);
		check(power_view, 16'h0005);
	endtask : run_frame

	// Full-width frames, with spare clocks and ignored strobes mid-frame.
	task automatic t_frames14();
		int i;
		for (i = 0; i < 8; i++) begin
			run_frame(CODES[i], 17 + (i % 2), (i == 2) ? 8 : ((i == 5) ? 15 : 0), 1'b1);
		end
	endtask : t_frames14

	// Light and deep standby entry and wake; deep is entered only once.
	task automatic t_standby();
		i_sacq_master.strobe_pulse();
		i_sacq_master.strobe_pulse();
		check(power_view, 16'h0015);
		i_sacq_master.strobe_pulse();
		check(power_view, 16'h0015);
		i_sacq_master.strobe_pulse();
		check(power_view, 16'h0009);
		i_sacq_master.sck_pulse();
		check(power_view, 16'h0005);
		run_frame(16'sh0abc, 17, 0, 1'b1);
		i_sacq_master.strobe_pulse();
		i_sacq_master.strobe_pulse();
		check(power_view, 16'h0015);
		i_sacq_master.sck_pulse();
		check(power_view, 16'h0005);
		run_frame(16'sh3210, 17, 0, 1'b1);
	endtask : t_standby

	// Narrow variant after a second reset with the strap low.
	task automatic t_frames12();
		int i;
		do_reset(1'b0);
		for (i = 0; i < 8; i++) begin
			run_frame(CODES[i], 17, 0, 1'b0);
		end
	endtask : t_frames12

	// Main sequence.
	initial begin
		fail_count   = 0;
		num_checks   = 0;
		fall_n       = 16;
		oe_hist      = 16'h0000;
		trk_first    = 1'b0;
		I_RST        = 1'b1;
		I_VARIANT_14 = 1'b1;
		I_INPUT_CODE = 16'sh0000;
		do_reset(1'b1);
		t_frames14();
		t_standby();
		t_frames12();
		give_verdict();
	end

	// Watchdog: the whole run needs well under 60 us.
	initial begin
		#300000;
		fail_count++;
		give_verdict();
	end
endmodule : test_sacq_top
`default_nettype wire
